// ---- verilog/nfm_top.sv ----
// Config-memory guard: temperature write inhibit, CRC check on load, fault masking, paging,
// setpoint DAC path, reached over APB. Assumes a PMBus front end outside forwards commands
// as APB writes and asks busAddrOk for each received address.
`timescale 1ns/1ns
`include "nfm_consts.svh"
module nfm_top #(
  parameter int MEM_WORDS = 64,
  parameter int NFAULT = 8,
  parameter int VOUT_LATENCY = `NFM_VOUT_LATENCY_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic signed [15:0] dieTemp,
  input wire logic writeProtect,
  input wire logic [NFAULT-1:0] faultIn,
  input wire logic logReq,
  input wire logic [15:0] logData,
  input wire logic [6:0] busAddr,
  output logic busAddrOk,
  output logic [1:0] channelEnablePin,
  output logic faultOutputZero,
  output logic faultOutputOne,
  output logic alertN,
  output logic [11:0] dacCode0,
  output logic [11:0] dacCode1
);
  logic [15:0] mem [MEM_WORDS];
  logic [15:0] memNext;
  logic [7:0] crcStep;
  nfm_pkg::nfm_state_t st_reg, st_next;
  logic [5:0] idx_reg, idx_next;
  logic [7:0] crc_reg, crc_next;
  logic crcErr_reg, crcErr_next;
  logic wrRej_reg, wrRej_next;
  nfm_pkg::nfm_wreq_t wq_reg, wq_next;
  logic page_reg, page_next;
  logic [NFAULT-1:0] fmask_reg, fmask_next, gmask0_reg, gmask0_next, gmask1_reg, gmask1_next;
  logic [NFAULT-1:0] amask_reg, amask_next, latched_reg, latched_next;
  nfm_pkg::nfm_resp_t resp_reg, resp_next;
  logic [1:0] range_reg, range_next;
  logic [11:0] vcmd0_reg, vcmd0_next, vcmd1_reg, vcmd1_next;
  logic [11:0] dac0_reg, dac0_next, dac1_reg, dac1_next;
  logic [31:0] lat_reg, lat_next;
  logic [15:0] hic_reg, hic_next;
  logic [7:0] crcStored_reg, crcStored_next;
  logic [31:0] prdata_next;
  logic pready_next, pslverr_next;
  logic [1:0] run_next;
  logic f0_next, f1_next, al_next, addrOk_next;
  logic wrInhibit, otShdn;
  logic acc, wr, rd, restoreCmd, memWrCmd;
  logic [NFAULT-1:0] active;
  logic shutdown;

  nfm_hyst u_wrinh (.clk(clk), .resetn(resetn), .ce(ce), .temp(dieTemp),
    .hi(`NFM_WR_INHIBIT_C), .lo(`NFM_WR_RELEASE_C), .flag(wrInhibit));
  nfm_hyst u_ot (.clk(clk), .resetn(resetn), .ce(ce), .temp(dieTemp),
    .hi(`NFM_OT_FAULT_C), .lo(16'(`NFM_OT_FAULT_C - `NFM_OT_HYST_C)), .flag(otShdn));
  nfm_crc8 u_crc (.crcIn(crc_reg), .dataIn(mem[idx_reg]), .crcOut(crcStep));

  // Link pace is the front end's concern; any APB rate is taken
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign restoreCmd = wr && paddr == `NFM_OFF_MEMCMD && pwdata[0];
  // Word writes are config; write protect blocks them, paging stays allowed
  assign memWrCmd = wr && paddr == `NFM_OFF_MEMDATA && !writeProtect;
  assign active = faultIn & ~fmask_reg;
  assign shutdown = (|(active | latched_reg)) || otShdn || crcErr_reg || hic_reg != 16'h0000;

  always_comb begin
    logic rejSet;
    rejSet = 1'b0;
    st_next = st_reg;
    idx_next = idx_reg;
    crc_next = crc_reg;
    crcErr_next = crcErr_reg;
    wrRej_next = wrRej_reg;
    wq_next = wq_reg;
    crcStored_next = crcStored_reg;
    memNext = mem[idx_reg];
    case (st_reg)
      nfm_pkg::NFM_IDLE: begin
        if (restoreCmd) begin
          st_next = nfm_pkg::NFM_LOAD;
          idx_next = 6'h00;
          crc_next = 8'hff;
        end else if (logReq) begin
          // Log writes land only in the log area
          wq_next = '{valid: 1'b1, isLog: 1'b1,
            addr: `NFM_LOG_BASE | 6'(idx_reg[3:0]), data: logData};
          st_next = nfm_pkg::NFM_WRITE;
        end else if (memWrCmd) begin
          if (wrInhibit) begin
            wrRej_next = 1'b1;
            rejSet = 1'b1;
          end else begin
            wq_next = '{valid: 1'b1, isLog: 1'b0, addr: pwdata[21:16], data: pwdata[15:0]};
            st_next = nfm_pkg::NFM_WRITE;
          end
        end
      end
      nfm_pkg::NFM_LOAD: begin
        crc_next = crcStep;
        if (idx_reg == 6'(`NFM_LOG_BASE - 1)) begin
          st_next = nfm_pkg::NFM_CHECK;
        end else begin
          idx_next = idx_reg + 6'h01;
        end
      end
      nfm_pkg::NFM_CHECK: begin
        crcErr_next = crc_reg != crcStored_reg;
        idx_next = 6'h00;
        st_next = nfm_pkg::NFM_IDLE;
      end
      nfm_pkg::NFM_WRITE: begin
        // Inhibit rechecked so a late rise drops the whole word
        if (wrInhibit || (wq_reg.isLog && wq_reg.addr < `NFM_LOG_BASE)) begin
          wrRej_next = 1'b1;
          rejSet = 1'b1;
        end else begin
          idx_next = wq_reg.addr;
          memNext = wq_reg.data;
          if (!wq_reg.isLog) begin
            crcStored_next = 8'hff;
          end
        end
        wq_next = '0;
        st_next = nfm_pkg::NFM_IDLE;
      end
      default: st_next = nfm_pkg::NFM_IDLE;
    endcase
    // A rejection in the clearing cycle wins over the W1C clear
    if (wr && paddr == `NFM_OFF_STATUS && pwdata[`NFM_STAT_WRREJ] && !rejSet) begin
      wrRej_next = 1'b0;
    end
    if (wr && paddr == `NFM_OFF_MEMCMD && pwdata[1]) begin
      crcStored_next = pwdata[15:8];
    end
  end

  always_comb begin
    page_next = page_reg;
    fmask_next = fmask_reg;
    gmask0_next = gmask0_reg;
    gmask1_next = gmask1_reg;
    amask_next = amask_reg;
    resp_next = resp_reg;
    range_next = range_reg;
    vcmd0_next = vcmd0_reg;
    vcmd1_next = vcmd1_reg;
    latched_next = latched_reg;
    hic_next = (hic_reg != 16'h0000) ? hic_reg - 16'h0001 : hic_reg;
    if (resp_reg == nfm_pkg::NFM_RESP_LATCH) begin
      latched_next = latched_reg | active;
    end else if (resp_reg == nfm_pkg::NFM_RESP_HICCUP && |active) begin
      hic_next = 16'(`NFM_HICCUP_CYC);
    end
    if (wr && !writeProtect) begin
      case (paddr)
        `NFM_OFF_PAGE: page_next = pwdata[0];
        `NFM_OFF_FMASK: fmask_next = pwdata[NFAULT-1:0];
        `NFM_OFF_FRESP: resp_next = nfm_pkg::nfm_resp_t'(pwdata[1:0]);
        `NFM_OFF_GMASK: begin
          gmask0_next = pwdata[NFAULT-1:0];
          gmask1_next = pwdata[NFAULT+15:16];
        end
        `NFM_OFF_ALMASK: amask_next = pwdata[NFAULT-1:0];
        `NFM_OFF_VOUT: begin
          range_next[page_reg] = pwdata[12];
          if (page_reg) begin
            vcmd1_next = pwdata[11:0];
          end else begin
            vcmd0_next = pwdata[11:0];
          end
        end
        // Fault still active in the clearing cycle stays latched
        `NFM_OFF_CTRL: if (pwdata[0]) latched_next = latched_next & active;
        default: ;
      endcase
    end else if (wr && paddr == `NFM_OFF_PAGE) begin
      page_next = pwdata[0];
    end
  end

  // Setpoint latency: the count starts at 1, which applies at once, so the DACs load the cycle after a VOUT write, inside the 10 ms figure
  always_comb begin
    dac0_next = dac0_reg;
    dac1_next = dac1_reg;
    lat_next = lat_reg;
    if (wr && paddr == `NFM_OFF_VOUT && !writeProtect) begin
      lat_next = 32'h0000_0001;
    end else if (lat_reg != 32'h0) begin
      if (lat_reg >= 32'(VOUT_LATENCY) || lat_reg == 32'h0000_0001) begin
        dac0_next = vcmd0_reg;
        dac1_next = vcmd1_reg;
        lat_next = 32'h0;
      end else begin
        lat_next = lat_reg + 32'h1;
      end
    end
  end

  always_comb begin
    prdata_next = 32'h0;
    pready_next = psel && !penable;
    pslverr_next = 1'b0;
    case (paddr)
      `NFM_OFF_CTRL: prdata_next = 32'h0;
      `NFM_OFF_STATUS: begin
        prdata_next[`NFM_STAT_MFR] = crcErr_reg;
        prdata_next[`NFM_STAT_CRCERR] = crcErr_reg;
        prdata_next[`NFM_STAT_WRINH] = wrInhibit;
        prdata_next[`NFM_STAT_OTSHDN] = otShdn;
        prdata_next[`NFM_STAT_BUSY] = st_reg != nfm_pkg::NFM_IDLE;
        prdata_next[`NFM_STAT_WRREJ] = wrRej_reg;
        prdata_next[`NFM_STAT_LATCHED] = |latched_reg;
      end
      `NFM_OFF_TEMP: prdata_next = 32'(unsigned'(dieTemp));
      `NFM_OFF_PAGE: prdata_next = {31'h0, page_reg};
      `NFM_OFF_FMASK: prdata_next = 32'(fmask_reg);
      `NFM_OFF_FRESP: prdata_next = {30'h0, resp_reg};
      `NFM_OFF_GMASK: prdata_next = 32'(gmask0_reg) | (32'(gmask1_reg) << 16);
      `NFM_OFF_ALMASK: prdata_next = 32'(amask_reg);
      `NFM_OFF_VOUT: prdata_next = {19'h0, range_reg[page_reg], page_reg ? vcmd1_reg : vcmd0_reg};
      `NFM_OFF_DAC: prdata_next = {4'h0, dac1_reg, 4'h0, dac0_reg};
      `NFM_OFF_MEMCMD: prdata_next = {16'h0, crcStored_reg, crc_reg};
      `NFM_OFF_MEMDATA: prdata_next = 32'h0;
      `NFM_OFF_BUSADDR: prdata_next = {25'h0, busAddr};
      default: pslverr_next = psel && !penable;
    endcase
    run_next = shutdown ? 2'b00 : 2'b11;
    f0_next = !(|(faultIn & ~gmask0_reg));
    f1_next = !(|(faultIn & ~gmask1_reg));
    al_next = !(crcErr_reg || |(faultIn & ~amask_reg));
    if (crcErr_reg) begin
      addrOk_next = busAddr == `NFM_ADDR_SPECIAL || busAddr == `NFM_ADDR_GLOBAL0
        || busAddr == `NFM_ADDR_GLOBAL1;
    end else begin
      addrOk_next = busAddr == `NFM_DEF_BUSADDR || busAddr == `NFM_ADDR_GLOBAL0
        || busAddr == `NFM_ADDR_GLOBAL1;
    end
  end

  always_ff @(posedge clk) begin
    if (ce && (st_reg == nfm_pkg::NFM_WRITE) && !wrInhibit) begin
      mem[idx_next] <= memNext;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= nfm_pkg::NFM_LOAD;
      idx_reg <= 6'h00;
      crc_reg <= 8'hff;
      crcErr_reg <= 1'b0;
      wrRej_reg <= 1'b0;
      wq_reg <= '0;
      crcStored_reg <= 8'hff;
      page_reg <= 1'b0;
      fmask_reg <= '0;
      gmask0_reg <= '0;
      gmask1_reg <= '0;
      amask_reg <= '0;
      resp_reg <= nfm_pkg::NFM_RESP_LATCH;
      range_reg <= 2'b00;
      vcmd0_reg <= 12'h000;
      vcmd1_reg <= 12'h000;
      dac0_reg <= 12'h000;
      dac1_reg <= 12'h000;
      lat_reg <= 32'h0;
      latched_reg <= '0;
      hic_reg <= 16'h0;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      channelEnablePin <= 2'b00;
      faultOutputZero <= 1'b1;
      faultOutputOne <= 1'b1;
      alertN <= 1'b1;
      busAddrOk <= 1'b0;
    end else if (ce) begin
      st_reg <= st_next;
      idx_reg <= idx_next;
      crc_reg <= crc_next;
      crcErr_reg <= crcErr_next;
      wrRej_reg <= wrRej_next;
      wq_reg <= wq_next;
      crcStored_reg <= crcStored_next;
      page_reg <= page_next;
      fmask_reg <= fmask_next;
      gmask0_reg <= gmask0_next;
      gmask1_reg <= gmask1_next;
      amask_reg <= amask_next;
      resp_reg <= resp_next;
      range_reg <= range_next;
      vcmd0_reg <= vcmd0_next;
      vcmd1_reg <= vcmd1_next;
      dac0_reg <= dac0_next;
      dac1_reg <= dac1_next;
      lat_reg <= lat_next;
      latched_reg <= latched_next;
      hic_reg <= hic_next;
      prdata <= prdata_next;
      pready <= pready_next;
      pslverr <= pslverr_next;
      channelEnablePin <= run_next;
      faultOutputZero <= f0_next;
      faultOutputOne <= f1_next;
      alertN <= al_next;
      busAddrOk <= addrOk_next;
    end
  end
  assign dacCode0 = dac0_reg;
  assign dacCode1 = dac1_reg;

  sequence s_crcBad;
    st_reg == nfm_pkg::NFM_CHECK && crc_reg != crcStored_reg;
  endsequence
  sequence s_pinsLow;
    ##2 (channelEnablePin == 2'b00 && !alertN);
  endsequence
  a_crc_pins_low: assert property (@(posedge clk) disable iff (!resetn)
    ce throughout (s_crcBad ##1 ce) |-> s_pinsLow) else $error("crc error pins not low");
  a_crc_status_bit: assert property (@(posedge clk) disable iff (!resetn)
    (ce and s_crcBad) |=> crcErr_reg) else $error("crc flag not set");
  a_fallback_addr: assert property (@(posedge clk) disable iff (!resetn)
    (ce && crcErr_reg && busAddr == 7'h40) |=> !busAddrOk) else $error("bad addr acked");
  a_inhibit_high: assert property (@(posedge clk) disable iff (!resetn)
    (ce && dieTemp > 16'sh0082) |=> wrInhibit) else $error("inhibit not set");
  a_inhibit_hold: assert property (@(posedge clk) disable iff (!resetn)
    (ce && dieTemp >= 16'sh007d && dieTemp <= 16'sh0082) |=> $stable(wrInhibit))
    else $error("inhibit changed in band");
  a_inhibit_release: assert property (@(posedge clk) disable iff (!resetn)
    (ce && dieTemp < 16'sh007d) |=> !wrInhibit) else $error("inhibit not released");
  a_write_dropped: assert property (@(posedge clk) disable iff (!resetn)
    (ce && st_reg == nfm_pkg::NFM_WRITE && wrInhibit)
    |=> mem[$past(wq_reg.addr)] == $past(mem[wq_reg.addr]))
    else $error("inhibited write stored");
  a_ot_shutdown: assert property (@(posedge clk) disable iff (!resetn)
    (ce && otShdn) |=> channelEnablePin == 2'b00) else $error("no ot shutdown");
  a_log_area: assert property (@(posedge clk) disable iff (!resetn)
    (st_reg == nfm_pkg::NFM_WRITE && wq_reg.isLog) |-> wq_reg.addr >= 6'h30)
    else $error("log outside area");
endmodule

// ---- verilog/nfm_consts.svh ----
// Register offsets, field positions, thresholds, bus addresses and timing counts for the config-memory guard.
// Assumes a 100 MHz clock and temperatures in signed whole degrees C.
`ifndef NFM_CONSTS_SVH
`define NFM_CONSTS_SVH
`define NFM_CLK_MHZ 100
`define NFM_OFF_CTRL 8'h00
`define NFM_OFF_STATUS 8'h04
`define NFM_OFF_TEMP 8'h08
`define NFM_OFF_PAGE 8'h0c
`define NFM_OFF_FMASK 8'h10
`define NFM_OFF_FRESP 8'h14
`define NFM_OFF_GMASK 8'h18
`define NFM_OFF_ALMASK 8'h1c
`define NFM_OFF_VOUT 8'h20
`define NFM_OFF_DAC 8'h24
`define NFM_OFF_MEMCMD 8'h28
`define NFM_OFF_MEMDATA 8'h2c
`define NFM_OFF_BUSADDR 8'h30
`define NFM_WR_INHIBIT_C 16'sh0082
`define NFM_WR_RELEASE_C 16'sh007d
`define NFM_OT_FAULT_C 16'sh00a0
`define NFM_OT_HYST_C 16'sh000a
`define NFM_ADDR_SPECIAL 7'h7c
`define NFM_ADDR_GLOBAL0 7'h5a
`define NFM_ADDR_GLOBAL1 7'h5b
`define NFM_STAT_MFR 0
`define NFM_STAT_CRCERR 1
`define NFM_STAT_WRINH 2
`define NFM_STAT_OTSHDN 3
`define NFM_STAT_BUSY 4
`define NFM_STAT_WRREJ 5
`define NFM_STAT_LATCHED 6
`define NFM_VOUT_LATENCY_MS 10
`define NFM_VOUT_LATENCY_CYC (`NFM_VOUT_LATENCY_MS * 1000 * `NFM_CLK_MHZ)
`define NFM_HICCUP_CYC 1000
`define NFM_LOG_BASE 6'h30
`define NFM_DEF_BUSADDR 7'h40
`endif

// ---- verilog/nfm_pkg.sv ----
// Types used by the config-memory guard top module.
// Assumes nfm_consts.svh supplies the numeric constants.
package nfm_pkg;
  typedef enum logic [3:0] {
    NFM_IDLE = 4'b0001,
    NFM_LOAD = 4'b0010,
    NFM_CHECK = 4'b0100,
    NFM_WRITE = 4'b1000
  } nfm_state_t;
  typedef enum logic [1:0] {
    NFM_RESP_IGNORE = 2'h0,
    NFM_RESP_HICCUP = 2'h1,
    NFM_RESP_LATCH = 2'h2
  } nfm_resp_t;
  typedef struct packed {
    logic valid;
    logic isLog;
    logic [5:0] addr;
    logic [15:0] data;
  } nfm_wreq_t;
endpackage

// ---- verilog/nfm_crc8.sv ----
// Bitwise CRC-8 (poly 0x07) step over a 16-bit word, MSB first, combinational.
// Assumes the caller registers the running value.
`timescale 1ns/1ns
module nfm_crc8 (
  input wire logic [7:0] crcIn,
  input wire logic [15:0] dataIn,
  output logic [7:0] crcOut
);
  always_comb begin
    logic [7:0] c;
    c = crcIn;
    for (int i = 15; i >= 0; i--) begin
      c = (c[7] ^ dataIn[i]) ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    end
    crcOut = c;
  end
endmodule

// ---- verilog/nfm_hyst.sv ----
// Hysteresis flag: sets above hi, clears below lo, else holds.
// Assumes temperature is a signed sample synchronous to clk.
`timescale 1ns/1ns
module nfm_hyst (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic signed [15:0] temp,
  input wire logic signed [15:0] hi,
  input wire logic signed [15:0] lo,
  output logic flag
);
  logic flag_reg;
  logic flag_next;
  always_comb begin
    flag_next = flag_reg;
    if (temp > hi) begin
      flag_next = 1'b1;
    end else if (temp < lo) begin
      flag_next = 1'b0;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flag_reg <= 1'b0;
    end else if (ce) begin
      flag_reg <= flag_next;
    end
  end
  assign flag = flag_reg;
endmodule

// ---- tb/nfm_apb_host.sv ----
// APB host model standing in for the front end that forwards host commands.
// Assumes the slave raises pready within 50 cycles of the access phase.
`timescale 1ns/1ns
module nfm_apb_host (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // Idle gap lets the host be prompt or slow; page values stay 0 or 1
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
      input int gap, output logic [31:0] rd, output logic err, output logic tmo);
    int n;
    n = 0;
    repeat (gap) @(posedge clk);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    tmo = (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the config-memory guard, all register traffic via the host model.
// Assumes a shortened setpoint latency of 8 cycles.
`timescale 1ns/1ns
`include "nfm_consts.svh"
module tb_top;
  logic clk, resetn, ce, logReq, writeProtect, busAddrOk, alertN;
  logic psel, penable, pwrite, pready, pslverr, faultOutputZero, faultOutputOne;
  logic [7:0] paddr;
  logic [7:0] faultIn;
  logic [31:0] pwdata, prdata, rdv;
  logic signed [15:0] dieTemp;
  logic [15:0] logData;
  logic [6:0] busAddr;
  logic [1:0] channelEnablePin;
  logic [11:0] dacCode0, dacCode1;
  logic [11:0] vcode [2];
  logic [15:0] mem [48];
  logic serr, tmo;
  int seed = 90;
  int errorCnt = 0;
  int checksDone = 0;
  logic signed [15:0] tempTab [9] = '{16'sh0082, 16'sh0083, 16'sh007e, 16'sh007d,
      16'sh007c, 16'sh00a0, 16'sh00a1, 16'sh0097, 16'sh0095};
  logic [1:0] expTab [9] = '{2'h0, 2'h1, 2'h1, 2'h1, 2'h0, 2'h1, 2'h3, 2'h3, 2'h1};
  logic [6:0] adrTab [5] = '{7'h40, `NFM_ADDR_SPECIAL, `NFM_ADDR_GLOBAL0,
      `NFM_ADDR_GLOBAL1, 7'h41};

  nfm_top #(.VOUT_LATENCY(8)) i_nfm_top (
    .clk(clk), .resetn(resetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dieTemp(dieTemp),
    .writeProtect(writeProtect), .faultIn(faultIn), .logReq(logReq),
    .logData(logData), .busAddr(busAddr), .busAddrOk(busAddrOk),
    .channelEnablePin(channelEnablePin), .faultOutputZero(faultOutputZero),
    .faultOutputOne(faultOutputOne), .alertN(alertN), .dacCode0(dacCode0),
    .dacCode1(dacCode1)
  );
  nfm_apb_host i_nfm_apb_host (
    .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", checksDone, errorCnt);
    if (errorCnt == 0 && checksDone > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      errorCnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    i_nfm_apb_host.xfer(wr, a, d, int'($unsigned($random(seed)) % 3), rdv, serr, tmo);
    if (tmo) begin
      errorCnt++;
      giveVerdict();
    end
  endtask
  task automatic stat();
    bus(1'b0, `NFM_OFF_STATUS, 32'h0);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Polls busy; a memory access that never finishes ends the run
  task automatic waitIdle();
    int n;
    n = 0;
    do begin
      stat();
      n++;
    end while (rdv[`NFM_STAT_BUSY] !== 1'b0 && n < 200);
    if (rdv[`NFM_STAT_BUSY] !== 1'b0) begin
      errorCnt++;
      giveVerdict();
    end
  endtask
  // Reference CRC-8, poly 07, init ff, bytes equal so byte order cannot matter
  function automatic logic [7:0] crcOf();
    logic [7:0] c;
    c = 8'hff;
    for (int w = 0; w < 48; w++) begin
      for (int k = 15; k >= 0; k--) begin
        c = (c[7] ^ mem[w][k]) ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction
  task automatic reload(input logic [7:0] crc);
    bus(1'b1, `NFM_OFF_MEMCMD, {16'h0, crc, 8'h02});
    waitIdle();
    bus(1'b1, `NFM_OFF_MEMCMD, 32'h1);
    waitIdle();
  endtask

  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    dieTemp = 16'sh0019;
    writeProtect = 1'b0;
    faultIn = 8'h00;
    logReq = 1'b0;
    logData = 16'h0;
    busAddr = 7'h40;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    waitIdle();
    for (int w = 0; w < 48; w++) begin
      mem[w] = {2{8'($random(seed))}};
      bus(1'b1, `NFM_OFF_MEMDATA, {10'h0, 6'(w), mem[w]});
      waitIdle();
    end
    reload(crcOf());
    check(rdv[1:0], 2'h0);
    cyc(3);
    check({channelEnablePin, alertN, busAddrOk}, 4'hf);
    $display("test crc_good done");
    // Hot write is deliberate: it must be dropped whole
    foreach (tempTab[i]) begin
      dieTemp <= tempTab[i];
      cyc(3);
      stat();
      check({rdv[3], rdv[2]}, expTab[i]);
      check(channelEnablePin, expTab[i][1] ? 2'h0 : 2'h3);
      if (i == 1) begin
        bus(1'b1, `NFM_OFF_MEMDATA, {10'h0, 6'h03, ~mem[3]});
        waitIdle();
        check(rdv[5], 1'b1);
        bus(1'b1, `NFM_OFF_STATUS, 32'h20);
        stat();
        check(rdv[5], 1'b0);
      end
    end
    dieTemp <= 16'sh0019;
    cyc(3);
    reload(crcOf());
    check(rdv[1], 1'b0);
    $display("test temperature done");
    for (int p = 0; p < 2; p++) begin
      vcode[p] = 12'($random(seed));
      bus(1'b1, `NFM_OFF_PAGE, 32'(p));
      bus(1'b1, `NFM_OFF_VOUT, {20'h0, vcode[p]});
    end
    cyc(20);
    check({dacCode1, dacCode0}, {vcode[1], vcode[0]});
    bus(1'b1, `NFM_OFF_VOUT, {19'h0, 1'b1, vcode[1]});
    bus(1'b0, `NFM_OFF_VOUT, 32'h0);
    check(rdv[12:0], {1'b1, vcode[1]});
    writeProtect <= 1'b1;
    bus(1'b1, `NFM_OFF_PAGE, 32'h0);
    bus(1'b1, `NFM_OFF_VOUT, {20'h0, ~vcode[0]});
    bus(1'b0, `NFM_OFF_PAGE, 32'h0);
    check(rdv[0], 1'b0);
    cyc(20);
    check(dacCode0, vcode[0]);
    writeProtect <= 1'b0;
    bus(1'b1, 8'h3c, 32'h1);
    check(serr, 1'b1);
    $display("test setpoint done");
    bus(1'b1, `NFM_OFF_ALMASK, 32'h0);
    bus(1'b1, `NFM_OFF_FMASK, 32'h0);
    bus(1'b1, `NFM_OFF_GMASK, 32'h0001_0000);
    // Ignore, hiccup, latch in turn
    for (int m = 0; m < 3; m++) begin
      bus(1'b1, `NFM_OFF_FRESP, 32'(m));
      faultIn <= 8'h01;
      cyc(5);
      check({faultOutputOne, faultOutputZero, alertN}, 3'h4);
      check(channelEnablePin, 2'h0);
      faultIn <= 8'h00;
      cyc(5);
      check(channelEnablePin, m == 0 ? 2'h3 : 2'h0);
      cyc(1095);
      check(channelEnablePin, m == 2 ? 2'h0 : 2'h3);
      bus(1'b1, `NFM_OFF_CTRL, 32'h1);
      cyc(3);
      check(channelEnablePin, 2'h3);
    end
    bus(1'b1, `NFM_OFF_FMASK, 32'h1);
    bus(1'b1, `NFM_OFF_ALMASK, 32'h1);
    bus(1'b1, `NFM_OFF_GMASK, 32'h0001_0001);
    bus(1'b1, `NFM_OFF_FRESP, 32'h2);
    faultIn <= 8'h01;
    cyc(5);
    check({channelEnablePin, faultOutputOne, faultOutputZero, alertN}, 5'h1f);
    faultIn <= 8'h00;
    $display("test faults done");
    logData <= 16'hbeef;
    logReq <= 1'b1;
    @(posedge clk);
    logReq <= 1'b0;
    waitIdle();
    reload(crcOf());
    check(rdv[1], 1'b0);
    $display("test fault_log done");
    reload(~crcOf());
    check(rdv[1:0], 2'h3);
    cyc(3);
    check({channelEnablePin, alertN}, 3'h0);
    foreach (adrTab[i]) begin
      busAddr <= adrTab[i];
      cyc(3);
      check(busAddrOk, (i > 0 && i < 4) ? 1'b1 : 1'b0);
    end
    $display("test crc_bad done");
    giveVerdict();
  end
endmodule
